// ==== design/step_loss_monitor_defs.svh ====
`ifndef STEP_LOSS_MONITOR_DEFS_SVH
`define STEP_LOSS_MONITOR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define A_CTRL     8'h00
`define A_SPR      8'h04
`define A_CPR      8'h08
`define A_THR      8'h0c
`define A_STAT     8'h10
`define A_ENC      8'h14
`define A_REV_ON   8'h18
`define A_REV_OFF  8'h1c

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define B_ST_SLIP  0
`define B_ST_ALARM 1
`define B_ST_PERR  2
`define B_ST_POFF  3
`define B_ST_RCAL  4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST   6'h00
`define SPR_RST    16'h00c8
`define CPR_RST    16'h0320
`define THR_RST    16'h0003

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ    50
`define VERIFY_US  10
`define VERIFY_CYC (`VERIFY_US * `CLK_MHZ)
`define DIV_STEPS  48

`endif

// ==== design/step_loss_monitor_pkg.sv ====
package step_loss_monitor_pkg;

  typedef enum logic [2:0] {
    S_MON, S_DIV, S_LOAD, S_RESTART, S_VERIFY, S_ALARM
  } fsm_e;

  // control word, bit 0 is slip_en
  typedef struct packed {
    logic corr_en;
    logic alm_slip;
    logic rev_inv;
    logic use_rev;
    logic enc_main;
    logic slip_en;
  } ctrl_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    logic [31:0] step_pos;
    logic        moving;
    logic        holding;
    logic        soft_stop;
    logic        hard_stop;
  } core_in_s;

  typedef struct packed {
    logic        halt;
    logic        load_pos;
    logic [31:0] load_value;
    logic        resume;
    logic        move_req;
    logic [31:0] move_target;
    logic        cmd_hold;
    logic        power_off;
  } core_out_s;

  typedef struct packed {
    fsm_e        fsm;
    ctrl_s       ctrl;
    logic [15:0] spr;
    logic [15:0] cpr;
    logic [15:0] thr;
    logic        enc_a;
    logic        enc_b;
    logic        rev_act;
    logic [31:0] enc_cnt;
    logic [31:0] ref_step;
    logic [31:0] ref_enc;
    logic        ref_valid;
    logic [31:0] rev_ref;
    logic [31:0] rev_on_pos;
    logic [31:0] rev_off_pos;
    logic        rev_cal;
    logic        was_moving;
    logic [47:0] div_num;
    logic [16:0] div_rem;
    logic [5:0]  div_cnt;
    logic        neg;
    logic [9:0]  wait_cnt;
    logic        soft_cnt;
    logic        slip;
    logic        alarm;
    logic        pos_err;
    core_out_s   co;
    logic [31:0] rdata;
  } st_s;

endpackage

// ==== design/step_loss_monitor.sv ====
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "step_loss_monitor_defs.svh"
module step_loss_monitor (
  // clock and reset
  input  wire logic                            i_clk,
  input  wire logic                            i_rst_n,
  // register port
  input  wire step_loss_monitor_pkg::bus_req_s i_bus,
  output logic [31:0]                          o_rdata,
  // motion core
  input  wire step_loss_monitor_pkg::core_in_s i_core,
  output step_loss_monitor_pkg::core_out_s     o_core,
  // feedback pins
  input  wire logic                            i_enc_a,
  input  wire logic                            i_enc_b,
  input  wire logic                            i_rev,
  // status
  output logic                                 o_slip,
  output logic                                 o_alarm,
  output logic                                 o_pos_err
);

  step_loss_monitor_pkg::st_s st_ff;
  step_loss_monitor_pkg::st_s nxt_st;

  // ----------------------------------------------------------------
  // mismatch arithmetic
  // ----------------------------------------------------------------
  logic signed [31:0] sd;
  logic signed [31:0] ed;
  logic signed [49:0] diff;
  logic        [49:0] mag;
  logic        [31:0] lim;
  logic        [31:0] emag;
  logic        [31:0] rd;
  logic        [31:0] rmag;
  logic        [31:0] rdev;
  logic               enc_err;
  logic               rev_err;
  logic               rev_now;
  logic               rev_rise;
  logic               rev_fall;
  logic               enc_det;
  logic               rev_det;
  logic               rev_chk;
  logic        [16:0] trial;
  logic        [31:0] quot;
  logic               correcting;

  // encoder counts scaled by steps per turn are compared against steps scaled
  // by counts per turn; cross-multiplying avoids a divider in the hot path
  always_comb begin
    sd   = $signed(i_core.step_pos - st_ff.ref_step);
    ed   = $signed(st_ff.enc_cnt - st_ff.ref_enc);
    diff = 50'(sd * $signed({1'b0, st_ff.cpr})) - 50'(ed * $signed({1'b0, st_ff.spr}));
    mag  = diff[49] ? 50'(-diff) : 50'(diff);
    lim  = {16'h0, st_ff.thr} * {16'h0, st_ff.cpr};
    enc_err = mag > {18'h0, lim};
    emag = ed[31] ? 32'(-ed) : 32'(ed);
  end

  // revolution distance versus one turn
  always_comb begin
    rd   = i_core.step_pos - st_ff.rev_ref;
    rmag = rd[31] ? 32'(-rd) : rd;
    rdev = (rmag > {16'h0, st_ff.spr}) ? rmag - {16'h0, st_ff.spr}
                                       : {16'h0, st_ff.spr} - rmag;
    rev_err = rdev > {16'h0, st_ff.thr};
  end

  // sensor polarity: low is active unless inverted
  assign rev_now  = st_ff.ctrl.rev_inv ? i_rev : ~i_rev;
  assign rev_rise = rev_now & ~st_ff.rev_act;
  assign rev_fall = ~rev_now & st_ff.rev_act;

  // sensor check only at an active edge under powered motion
  assign rev_chk = st_ff.ctrl.slip_en & st_ff.ctrl.use_rev & rev_rise
                   & i_core.moving;
  assign rev_det = (st_ff.fsm == step_loss_monitor_pkg::S_MON) & rev_chk
                   & st_ff.rev_cal & rev_err;

  // encoder check is off when the encoder is the main position source
  assign enc_det = (st_ff.fsm == step_loss_monitor_pkg::S_MON)
                   & st_ff.ctrl.slip_en & ~st_ff.ctrl.enc_main
                   & ~st_ff.ctrl.use_rev & st_ff.ref_valid
                   & (i_core.moving | i_core.holding) & enc_err;

  assign trial = {st_ff.div_rem[15:0], st_ff.div_num[47]};
  assign quot  = st_ff.div_num[31:0];
  assign correcting = (st_ff.fsm == step_loss_monitor_pkg::S_DIV)
                      | (st_ff.fsm == step_loss_monitor_pkg::S_LOAD)
                      | (st_ff.fsm == step_loss_monitor_pkg::S_RESTART)
                      | (st_ff.fsm == step_loss_monitor_pkg::S_VERIFY);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.co.halt     = 1'b0;
    nxt_st.co.load_pos = 1'b0;
    nxt_st.co.resume   = 1'b0;
    nxt_st.co.move_req = 1'b0;
    nxt_st.rdata       = 32'h0;
    nxt_st.enc_a       = i_enc_a;
    nxt_st.enc_b       = i_enc_b;
    nxt_st.rev_act     = rev_now;

    // x4 decode; a simultaneous change of both channels is dropped
    if ((i_enc_a ^ st_ff.enc_a) ^ (i_enc_b ^ st_ff.enc_b)) begin
      if (i_enc_a ^ st_ff.enc_b) begin
        nxt_st.enc_cnt = st_ff.enc_cnt + 32'h1;
      end else begin
        nxt_st.enc_cnt = st_ff.enc_cnt - 32'h1;
      end
    end

    // both sensor transitions capture the step position
    if (rev_rise) begin
      nxt_st.rev_on_pos = i_core.step_pos;
    end
    if (rev_fall) begin
      nxt_st.rev_off_pos = i_core.step_pos;
    end

    // register writes come first so that hardware sets below win
    if (i_bus.wr) begin
      if (i_bus.addr == `A_CTRL) begin
        nxt_st.ctrl = step_loss_monitor_pkg::ctrl_s'(i_bus.wdata[5:0]);
      end else if (i_bus.addr == `A_SPR) begin
        nxt_st.spr = i_bus.wdata[15:0];
      end else if (i_bus.addr == `A_CPR) begin
        nxt_st.cpr = i_bus.wdata[15:0];
      end else if (i_bus.addr == `A_THR) begin
        nxt_st.thr = i_bus.wdata[15:0];
      end else if (i_bus.addr == `A_STAT) begin
        if (i_bus.wdata[`B_ST_SLIP]) begin
          nxt_st.slip = 1'b0;
        end
      end
      // any settings write takes a fresh reference and drops calibration
      if (i_bus.addr <= `A_THR) begin
        nxt_st.ref_step  = i_core.step_pos;
        nxt_st.ref_enc   = st_ff.enc_cnt;
        nxt_st.ref_valid = nxt_st.ctrl.slip_en;
        nxt_st.rev_cal   = 1'b0;
      end
    end

    // reads answer one cycle later; unmapped reads return zero
    if (i_bus.rd) begin
      if (i_bus.addr == `A_CTRL) begin
        nxt_st.rdata = {26'h0, st_ff.ctrl};
      end else if (i_bus.addr == `A_SPR) begin
        nxt_st.rdata = {16'h0, st_ff.spr};
      end else if (i_bus.addr == `A_CPR) begin
        nxt_st.rdata = {16'h0, st_ff.cpr};
      end else if (i_bus.addr == `A_THR) begin
        nxt_st.rdata = {16'h0, st_ff.thr};
      end else if (i_bus.addr == `A_STAT) begin
        nxt_st.rdata[`B_ST_SLIP]  = st_ff.slip;
        nxt_st.rdata[`B_ST_ALARM] = st_ff.alarm;
        nxt_st.rdata[`B_ST_PERR]  = st_ff.pos_err;
        nxt_st.rdata[`B_ST_POFF]  = st_ff.co.power_off;
        nxt_st.rdata[`B_ST_RCAL]  = st_ff.rev_cal;
      end else if (i_bus.addr == `A_ENC) begin
        nxt_st.rdata = st_ff.enc_cnt;
      end else if (i_bus.addr == `A_REV_ON) begin
        nxt_st.rdata = st_ff.rev_on_pos;
      end else if (i_bus.addr == `A_REV_OFF) begin
        nxt_st.rdata = st_ff.rev_off_pos;
      end
    end

    // sensor calibration starts at the first active edge while moving
    if (rev_chk && st_ff.fsm == step_loss_monitor_pkg::S_MON) begin
      nxt_st.rev_ref = i_core.step_pos;
      nxt_st.rev_cal = 1'b1;
    end

    case (st_ff.fsm)
      step_loss_monitor_pkg::S_MON: begin
        if (i_core.moving) begin
          nxt_st.co.power_off = 1'b0;
        end
        if (i_core.hard_stop) begin
          nxt_st.rev_cal = 1'b0;
        end
        if (enc_det || rev_det) begin
          nxt_st.slip = 1'b1;
        end
        if (enc_det) begin
          nxt_st.pos_err = 1'b1;
        end
        if (enc_det && st_ff.ctrl.corr_en && st_ff.cpr != 16'h0) begin
          // stop, then scale the encoder travel back into steps
          nxt_st.co.halt        = 1'b1;
          nxt_st.co.cmd_hold    = 1'b1;
          nxt_st.co.move_target = i_core.step_pos;
          nxt_st.was_moving     = i_core.moving;
          nxt_st.div_num        = {16'h0, emag} * {32'h0, st_ff.spr};
          nxt_st.div_rem        = 17'h0;
          nxt_st.div_cnt        = 6'h0;
          nxt_st.neg            = ed[31];
          nxt_st.soft_cnt       = 1'b0;
          nxt_st.fsm            = step_loss_monitor_pkg::S_DIV;
        end else if ((enc_det || rev_det) && st_ff.ctrl.alm_slip) begin
          nxt_st.alarm        = 1'b1;
          nxt_st.co.power_off = 1'b1;
          nxt_st.fsm          = step_loss_monitor_pkg::S_ALARM;
        end
      end
      step_loss_monitor_pkg::S_DIV: begin
        // restoring division, one quotient bit per clock
        nxt_st.div_num = {st_ff.div_num[46:0], 1'b0};
        if (trial >= {1'b0, st_ff.cpr}) begin
          nxt_st.div_rem    = trial - {1'b0, st_ff.cpr};
          nxt_st.div_num[0] = 1'b1;
        end else begin
          nxt_st.div_rem = trial;
        end
        nxt_st.div_cnt = st_ff.div_cnt + 6'h1;
        if (st_ff.div_cnt == 6'(`DIV_STEPS - 1)) begin
          nxt_st.fsm = step_loss_monitor_pkg::S_LOAD;
        end
      end
      step_loss_monitor_pkg::S_LOAD: begin
        // quotient beyond 32 bits is lost; only a runaway axis gets there
        nxt_st.co.load_pos   = 1'b1;
        nxt_st.co.load_value = st_ff.neg ? st_ff.ref_step - quot
                                         : st_ff.ref_step + quot;
        nxt_st.fsm           = step_loss_monitor_pkg::S_RESTART;
      end
      step_loss_monitor_pkg::S_RESTART: begin
        if (st_ff.was_moving) begin
          nxt_st.co.resume = 1'b1;
        end else begin
          nxt_st.co.move_req = 1'b1;
        end
        nxt_st.wait_cnt = 10'h0;
        nxt_st.fsm      = step_loss_monitor_pkg::S_VERIFY;
      end
      step_loss_monitor_pkg::S_VERIFY: begin
        nxt_st.wait_cnt = st_ff.wait_cnt + 10'h1;
        if (st_ff.wait_cnt == 10'(`VERIFY_CYC - 1)) begin
          nxt_st.co.cmd_hold = 1'b0;
          if (enc_err) begin
            nxt_st.alarm        = 1'b1;
            nxt_st.co.power_off = 1'b1;
            nxt_st.fsm          = step_loss_monitor_pkg::S_ALARM;
          end else begin
            nxt_st.pos_err = 1'b0;
            nxt_st.fsm     = step_loss_monitor_pkg::S_MON;
          end
        end
      end
      step_loss_monitor_pkg::S_ALARM: begin
        // a stop command leaves alarm with a fresh reference
        if (i_core.hard_stop || i_core.soft_stop) begin
          nxt_st.alarm        = 1'b0;
          nxt_st.co.power_off = 1'b0;
          nxt_st.rev_cal      = 1'b0;
          nxt_st.ref_step     = i_core.step_pos;
          nxt_st.ref_enc      = st_ff.enc_cnt;
          nxt_st.ref_valid    = st_ff.ctrl.slip_en;
          nxt_st.fsm          = step_loss_monitor_pkg::S_MON;
        end
      end
      default: begin
        nxt_st.fsm = step_loss_monitor_pkg::S_MON;
      end
    endcase

    // stops are ignored while correcting, except a second soft stop
    if (correcting && i_core.soft_stop) begin
      if (st_ff.soft_cnt) begin
        nxt_st.co.power_off = 1'b1;
        nxt_st.co.cmd_hold  = 1'b0;
        nxt_st.fsm          = step_loss_monitor_pkg::S_MON;
      end else begin
        nxt_st.soft_cnt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // sensor sample resets inactive, matching a pulled-up open input
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff         <= '0;
      st_ff.fsm     <= step_loss_monitor_pkg::S_MON;
      st_ff.ctrl    <= step_loss_monitor_pkg::ctrl_s'(`CTRL_RST);
      st_ff.spr     <= `SPR_RST;
      st_ff.cpr     <= `CPR_RST;
      st_ff.thr     <= `THR_RST;
      st_ff.rev_act <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata   = st_ff.rdata;
  assign o_core    = st_ff.co;
  assign o_slip    = st_ff.slip;
  assign o_alarm   = st_ff.alarm;
  assign o_pos_err = st_ff.pos_err;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_x4_count;
    ((i_enc_a != st_ff.enc_a) && (i_enc_b == st_ff.enc_b))
      |=> (st_ff.enc_cnt != $past(st_ff.enc_cnt));
  endproperty
  a_x4_count: assert property (p_x4_count) else $error("x4 edge not counted");

  property p_polarity;
    st_ff.rev_act == $past(st_ff.ctrl.rev_inv ? i_rev : ~i_rev);
  endproperty
  a_polarity: assert property (p_polarity) else $error("sensor polarity wrong");

  property p_ref_latch;
    (i_bus.wr && i_bus.addr == `A_CTRL && i_bus.wdata[0])
      |=> (st_ff.ref_step == $past(i_core.step_pos)) && st_ff.ref_valid;
  endproperty
  a_ref_latch: assert property (p_ref_latch) else $error("reference not latched");

  property p_no_alarm_opt;
    (enc_det && !st_ff.ctrl.corr_en && !st_ff.ctrl.alm_slip)
      |=> !o_alarm && o_slip;
  endproperty
  a_no_alarm_opt: assert property (p_no_alarm_opt) else $error("alarm without option");

  property p_alarm_off;
    (st_ff.fsm == step_loss_monitor_pkg::S_MON && (enc_det || rev_det)
      && !st_ff.ctrl.corr_en && st_ff.ctrl.alm_slip)
      |=> o_alarm && o_core.power_off;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm did not de-energize");

  sequence s_halt;
    o_core.halt ##1 (st_ff.fsm == step_loss_monitor_pkg::S_DIV);
  endsequence
  sequence s_reload;
    ##[47:49] o_core.load_pos ##1 (o_core.resume || o_core.move_req);
  endsequence
  property p_correct;
    (enc_det && st_ff.ctrl.corr_en && st_ff.cpr != 16'h0 && !i_core.soft_stop)
      |=> s_halt ##0 s_reload;
  endproperty
  a_correct: assert property (p_correct) else $error("correction sequence broken");

  property p_err_set;
    enc_det |=> o_pos_err;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_fail_alarm;
    (st_ff.fsm == step_loss_monitor_pkg::S_VERIFY
      && st_ff.wait_cnt == 10'(`VERIFY_CYC - 1) && enc_err && !i_core.soft_stop)
      |=> o_alarm && o_pos_err;
  endproperty
  a_fail_alarm: assert property (p_fail_alarm) else $error("failed fix not alarmed");

  property p_cmd_hold;
    (st_ff.fsm == step_loss_monitor_pkg::S_LOAD
      || st_ff.fsm == step_loss_monitor_pkg::S_RESTART) |-> o_core.cmd_hold;
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command status released");

  property p_hard_recal;
    (st_ff.fsm == step_loss_monitor_pkg::S_MON && i_core.hard_stop && !rev_chk)
      |=> !st_ff.rev_cal;
  endproperty
  a_hard_recal: assert property (p_hard_recal) else $error("calibration kept");

  property p_zero_speed;
    (rev_rise && !i_core.moving) |-> !rev_det;
  endproperty
  a_zero_speed: assert property (p_zero_speed) else $error("slip at zero speed");

endmodule

// ==== testbench/enc_model.sv ====
`timescale 1ns/1ns
// ------------------------------
// quadrature encoder and shaft sensor
// ------------------------------
module enc_model (
  // clock
  input  wire logic i_clk,
  // feedback pins
  output logic      o_enc_a,
  output logic      o_enc_b,
  output logic      o_rev
);
  logic [1:0] ph;
  // gray order 00,10,11,01 counts up; only one channel moves per count
  assign o_enc_a = ph[1] ^ ph[0];
  assign o_enc_b = ph[1];
  // sensor line is pulled high, so a dark slot reads inactive
  initial begin
    ph    = 2'h0;
    o_rev = 1'b1;
  end
  // n counts, sign gives direction; four counts per full step at bench scale
  task automatic move(input int n);
    for (int k = 0; k < (n < 0 ? -n : n); k++) begin
      @(posedge i_clk);
      ph <= (n < 0) ? ph - 2'h1 : ph + 2'h1;
    end
  endtask
  // sensor level, low while light reaches the detector
  task automatic rev_drive(input logic lvl);
    @(posedge i_clk);
    o_rev <= lvl;
  endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`include "step_loss_monitor_defs.svh"
module tb;
  logic                             i_clk;
  logic                             i_rst_n;
  step_loss_monitor_pkg::bus_req_s  bus;
  step_loss_monitor_pkg::core_in_s  core;
  step_loss_monitor_pkg::core_out_s co;
  logic [31:0]                      rdata;
  logic                             enc_a;
  logic                             enc_b;
  logic                             rev;
  logic                             slip;
  logic                             alarm;
  logic                             pos_err;
  int                               err_count;
  int                               n_compared;

  step_loss_monitor i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_core(core), .o_core(co), .i_enc_a(enc_a), .i_enc_b(enc_b), .i_rev(rev),
    .o_slip(slip), .o_alarm(alarm), .o_pos_err(pos_err));
  enc_model i_enc (.i_clk(i_clk), .o_enc_a(enc_a), .o_enc_b(enc_b), .o_rev(rev));

  always #10 i_clk = ~i_clk;

  // ------------------------------
  // access and compare tasks
  // ------------------------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: level %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 chk_reg(rdata, exp);
  endtask
  task automatic core_set(input logic [31:0] p, input logic mv, input logic hd);
    @(posedge i_clk);
    core.step_pos <= p;
    core.moving   <= mv;
    core.holding  <= hd;
  endtask
  task automatic stop_pulse(input logic hard);
    @(posedge i_clk);
    core.hard_stop <= hard;
    core.soft_stop <= !hard;
    @(posedge i_clk);
    core.hard_stop <= 1'b0;
    core.soft_stop <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  // bounded wait; a missing answer ends the run
  task automatic wait_for(input int sel, input int lim);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < lim && !hit; k++) begin
      @(posedge i_clk);
      #1;
      case (sel)
        0: hit = (co.halt === 1'b1);
        1: hit = (co.load_pos === 1'b1);
        2: hit = (co.move_req === 1'b1);
        3: hit = (co.cmd_hold === 1'b0);
        default: hit = (alarm === 1'b1);
      endcase
    end
    if (!hit) begin
      err_count++;
      $display("unexpected at %0t: no answer from the block", $time);
      stop_test();
    end
  endtask
  // step and encoder advance together, so divergence never passes one step
  task automatic track(input int n);
    for (int k = 0; k < n; k++) begin
      core.step_pos <= core.step_pos + 32'h1;
      i_enc.move(4);
    end
  endtask
  // active-low pulse; step position differs between its two edges
  task automatic rev_ev(input logic [31:0] lo, input logic [31:0] hi);
    @(posedge i_clk);
    core.step_pos <= lo;
    i_enc.rev_drive(1'b0);
    repeat (5) @(posedge i_clk);
    core.step_pos <= hi;
    i_enc.rev_drive(1'b1);
    repeat (5) @(posedge i_clk);
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    i_clk      = 1'b0;
    i_rst_n    = 1'b0;
    bus        = '0;
    core       = '0;
    err_count  = 0;
    n_compared = 0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk(`A_CTRL, 32'h0);
    rd_chk(`A_SPR, {16'h0, `SPR_RST});
    rd_chk(`A_CPR, {16'h0, `CPR_RST});
    rd_chk(`A_THR, {16'h0, `THR_RST});
    rd_chk(`A_STAT, 32'h0);
    rd_chk(8'h20, 32'h0);
    i_enc.move(8);
    i_enc.move(-3);
    settle();
    rd_chk(`A_ENC, 32'h5);
    // encoder slip without alarm, then cleared
    wr(`A_CTRL, 32'h1);
    core_set(32'h0, 1'b1, 1'b0);
    track(10);
    settle();
    chk_bit(slip, 1'b0);
    core_set(32'd20, 1'b1, 1'b0);
    settle();
    chk_bit(slip, 1'b1);
    chk_bit(alarm, 1'b0);
    core_set(32'd20, 1'b0, 1'b0);
    wr(`A_STAT, 32'h1);
    rd_chk(`A_STAT, 32'h4);
    wr(`A_CTRL, 32'h3);
    core_set(32'd40, 1'b1, 1'b0);
    settle();
    chk_bit(slip, 1'b0);
    // slip with alarm option, left by a stop
    wr(`A_CTRL, 32'h11);
    core_set(32'd60, 1'b1, 1'b0);
    settle();
    chk_bit(alarm, 1'b1);
    chk_bit(co.power_off, 1'b1);
    core_set(32'd60, 1'b0, 1'b0);
    stop_pulse(1'b0);
    settle();
    chk_bit(alarm, 1'b0);
    wr(`A_STAT, 32'h1);
    // correction during a move, with a stop that must be ignored
    wr(`A_THR, 32'h3);
    wr(`A_CTRL, 32'h21);
    core_set(32'd70, 1'b1, 1'b0);
    wait_for(0, 5);
    chk_bit(co.cmd_hold, 1'b1);
    chk_bit(pos_err, 1'b1);
    stop_pulse(1'b1);
    wait_for(1, 60);
    chk_reg(co.load_value, 32'd60);
    core_set(32'd60, 1'b1, 1'b0);
    #1 chk_bit(co.resume, 1'b1);
    repeat (100) @(posedge i_clk);
    #1 chk_bit(co.cmd_hold, 1'b1);
    wait_for(3, 600);
    chk_bit(pos_err, 1'b0);
    chk_bit(alarm, 1'b0);
    // correction while holding that never converges
    core_set(32'd60, 1'b0, 1'b1);
    repeat (50) @(posedge i_clk);
    wr(`A_CTRL, 32'h21);
    core_set(32'd80, 1'b0, 1'b1);
    wait_for(0, 5);
    wait_for(2, 60);
    chk_reg(co.move_target, 32'd80);
    wait_for(4, 700);
    chk_bit(pos_err, 1'b1);
    chk_bit(co.power_off, 1'b1);
    core_set(32'd80, 1'b0, 1'b0);
    stop_pulse(1'b0);
    wr(`A_STAT, 32'h1);
    // revolution sensor, normal then inverted
    wr(`A_CTRL, 32'h5);
    core_set(32'd100, 1'b1, 1'b0);
    rev_ev(32'd100, 32'd104);
    rev_ev(32'd300, 32'd304);
    chk_bit(slip, 1'b0);
    rev_ev(32'd510, 32'd514);
    chk_bit(slip, 1'b1);
    rd_chk(`A_REV_ON, 32'd510);
    rd_chk(`A_REV_OFF, 32'd514);
    core_set(32'd514, 1'b0, 1'b0);
    wr(`A_STAT, 32'h1);
    stop_pulse(1'b1);
    core_set(32'd514, 1'b1, 1'b0);
    rev_ev(32'd900, 32'd904);
    chk_bit(slip, 1'b0);
    wr(`A_CTRL, 32'hd);
    rev_ev(32'd1500, 32'd1600);
    rd_chk(`A_REV_ON, 32'd1600);
    rd_chk(`A_REV_OFF, 32'd1500);
    core_set(32'd1600, 1'b0, 1'b0);
    wr(`A_STAT, 32'h1);
    rev_ev(32'd2000, 32'd2004);
    chk_bit(slip, 1'b0);
    rd_chk(`A_REV_ON, 32'd2004);
    stop_test();
  end
endmodule
